/* File: src/fesp_top.sv */
// Flash fault status flags and program-flash protection register behind an APB slave.
// Assumes fault events and protection checks come from the flash controller as
// one-cycle pulses synchronous to clock, and the reset loader delivers one byte.
`timescale 1ns/1ps
`default_nettype none

module fesp_top
  import fesp_pkg::*;
#(
  parameter logic [23:0] PF_BASE = 24'h7F_0000
) (
  // Clock and reset.
  input  wire logic               clock,
  input  wire logic               rst,
  // APB slave.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Flash controller events.
  input  wire fesp_fault_evt_type fault_evt,
  input  wire fesp_load_type      prot_load,
  input  wire fesp_cmd_type       cmd,
  // Results.
  output logic                    cmd_refused,
  output logic                    cmd_granted,
  output logic                    prot_loaded,
  output logic                    double_fault_irq,
  output logic                    single_fault_irq
);

  typedef struct packed {
    fesp_prot_type prot;
    logic          double_fault_flag;
    logic          single_fault_flag;
    logic          double_fault_irq_enable;
    logic          single_fault_irq_enable;
    logic          ignore_single_fault;
    logic          protection_violation_flag;
    logic          loaded;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    logic          refused;
    logic          granted;
    logic          irq_dbl;
    logic          irq_sgl;
  } fesp_state_type;

  fesp_state_type st_q;
  fesp_state_type st_d;

  // Scenario index of a protection value.
  function automatic logic [2:0] scen_of(input fesp_prot_type p);
    logic [2:0] s;
    s = 3'h0;
    if (p.protection_open) begin
      s = {1'b1, p.high_window_disable, p.low_window_disable};
    end else begin
      s = {1'b0, p.low_window_disable, p.high_window_disable};
    end
    return s;
  endfunction

  // Whether an address is protected under a given protection value.
  function automatic logic addr_protected(input fesp_prot_type p, input logic [22:0] a);
    logic [23:0] ax;
    logic [23:0] hi_base;
    logic [23:0] lo_end;
    logic        in_hi;
    logic        in_lo;
    logic        in_pf;
    logic        win;
    ax      = {1'b0, a};
    hi_base = PF_TOP_EXCL - (HI_MIN_SIZE << p.high_window_size);
    lo_end  = LO_BASE + (LO_MIN_SIZE << p.low_window_size);
    in_pf   = (ax >= PF_BASE) && (ax < PF_TOP_EXCL);
    in_hi   = !p.high_window_disable && (ax >= hi_base) && (ax < PF_TOP_EXCL);
    in_lo   = !p.low_window_disable && (ax >= LO_BASE) && (ax < lo_end);
    win     = in_hi || in_lo;
    // With both windows off this yields all or nothing, depending on the open bit.
    if (p.protection_open) begin
      return in_pf && win;
    end
    return in_pf && !win;
  endfunction

  logic          setup_phase;
  logic          wr_take;
  logic [7:0]    sel_idx;
  logic          aligned;
  logic          hit_cfg;
  logic          hit_err;
  logic          hit_cmd;
  logic          hit_fault;
  logic          hit_prot;
  fesp_prot_type wr_prot;
  logic          wr_allowed;
  logic          cmd_prot;

  assign setup_phase = psel && !penable && !st_q.pready;
  // A write lands only in the access cycle that the slave answers.
  assign wr_take     = psel && penable && st_q.pready && pwrite;
  assign sel_idx     = paddr[9:2];
  assign aligned     = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign hit_cfg     = aligned && (sel_idx == IDX_CONFIG);
  assign hit_err     = aligned && (sel_idx == IDX_ERR_CFG);
  assign hit_cmd     = aligned && (sel_idx == IDX_CMD_STAT);
  assign hit_fault   = aligned && (sel_idx == IDX_FAULT);
  assign hit_prot    = aligned && (sel_idx == IDX_PROT);

  // Size fields follow the write only while the matching window is switched off.
  always_comb begin
    wr_prot = st_q.prot;
    wr_prot.protection_open     = pwdata[7];
    wr_prot.high_window_disable = pwdata[5];
    wr_prot.low_window_disable  = pwdata[2];
    if (st_q.prot.high_window_disable) begin
      wr_prot.high_window_size = pwdata[4:3];
    end
    if (st_q.prot.low_window_disable) begin
      wr_prot.low_window_size = pwdata[1:0];
    end
  end

  assign wr_allowed = PROT_TRANS[scen_of(st_q.prot)][scen_of(wr_prot)];
  assign cmd_prot   = cmd.block_erase ? (scen_of(st_q.prot) != SCEN_OPEN)
                                      : addr_protected(st_q.prot, cmd.addr);

  always_comb begin
    st_d = st_q;
    st_d.pready  = setup_phase;
    st_d.refused = cmd.valid && cmd_prot;
    st_d.granted = cmd.valid && !cmd_prot;

    if (setup_phase) begin
      st_d.pslverr = !(hit_cfg || hit_err || hit_cmd || hit_fault || hit_prot);
      st_d.prdata  = 32'h0000_0000;
      if (hit_cfg) begin
        st_d.prdata[BIT_IGNORE_SF] = st_q.ignore_single_fault;
      end
      if (hit_err) begin
        st_d.prdata[BIT_DOUBLE_FAULT] = st_q.double_fault_irq_enable;
        st_d.prdata[BIT_SINGLE_FAULT] = st_q.single_fault_irq_enable;
      end
      if (hit_cmd) begin
        st_d.prdata[BIT_VIOLATION] = st_q.protection_violation_flag;
      end
      if (hit_fault) begin
        st_d.prdata[BIT_DOUBLE_FAULT] = st_q.double_fault_flag;
        st_d.prdata[BIT_SINGLE_FAULT] = st_q.single_fault_flag;
      end
      if (hit_prot) begin
        st_d.prdata[7:0] = st_q.prot;
      end
    end

    if (wr_take && hit_cfg) begin
      st_d.ignore_single_fault = pwdata[BIT_IGNORE_SF];
    end
    if (wr_take && hit_err) begin
      st_d.double_fault_irq_enable = pwdata[BIT_DOUBLE_FAULT];
      st_d.single_fault_irq_enable = pwdata[BIT_SINGLE_FAULT];
    end
    if (wr_take && hit_fault && pwdata[BIT_DOUBLE_FAULT]) begin
      st_d.double_fault_flag = 1'b0;
    end
    if (wr_take && hit_fault && pwdata[BIT_SINGLE_FAULT]) begin
      st_d.single_fault_flag = 1'b0;
    end
    if (wr_take && hit_cmd && pwdata[BIT_VIOLATION]) begin
      st_d.protection_violation_flag = 1'b0;
    end
    // A rejected scenario change leaves the register on the scenario in force.
    if (wr_take && hit_prot && st_q.loaded && wr_allowed) begin
      st_d.prot = wr_prot;
    end

    // Hardware sets win over a clear in the same cycle.
    if (fault_evt.double_fault || fault_evt.busy_block_read) begin
      st_d.double_fault_flag = 1'b1;
    end
    if (!st_q.ignore_single_fault && (fault_evt.single_fault || fault_evt.busy_block_read)) begin
      st_d.single_fault_flag = 1'b1;
    end
    if (cmd.valid && cmd_prot) begin
      st_d.protection_violation_flag = 1'b1;
    end

    // Only the first load after reset is taken; later strobes cannot lower protection.
    if (prot_load.valid && !st_q.loaded) begin
      st_d.loaded = 1'b1;
      st_d.prot   = prot_load.double_fault ? fesp_prot_type'(PROT_FULL)
                                           : fesp_prot_type'(prot_load.value);
    end

    st_d.irq_dbl = st_d.double_fault_flag && st_d.double_fault_irq_enable;
    st_d.irq_sgl = st_d.single_fault_flag && st_d.single_fault_irq_enable;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.prot <= fesp_prot_type'(PROT_FULL);
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata           = st_q.prdata;
  assign pready           = st_q.pready;
  assign pslverr          = st_q.pslverr;
  assign cmd_refused      = st_q.refused;
  assign cmd_granted      = st_q.granted;
  assign prot_loaded      = st_q.loaded;
  assign double_fault_irq = st_q.irq_dbl;
  assign single_fault_irq = st_q.irq_sgl;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic wr_fault;
  assign wr_fault = wr_take && hit_fault;

  a_dbl_set: assert property (fault_evt.double_fault |=> st_q.double_fault_flag)
    else $error("double fault not flagged");
  a_dbl_clear: assert property (wr_fault && pwdata[1] && !fault_evt.double_fault
      && !fault_evt.busy_block_read |=> !st_q.double_fault_flag)
    else $error("double fault flag not cleared");
  a_dbl_keep: assert property (wr_fault && !pwdata[1] && st_q.double_fault_flag
      |=> st_q.double_fault_flag)
    else $error("double fault flag lost on zero write");
  a_sgl_set: assert property (!st_q.ignore_single_fault && fault_evt.single_fault
      |=> st_q.single_fault_flag)
    else $error("single fault not flagged");
  a_sgl_ignored: assert property (st_q.ignore_single_fault && !st_q.single_fault_flag
      && !fault_evt.busy_block_read |=> !st_q.single_fault_flag)
    else $error("ignored single fault flagged");
  a_sgl_clear: assert property (wr_fault && pwdata[0] && !fault_evt.single_fault
      && !fault_evt.busy_block_read |=> !st_q.single_fault_flag)
    else $error("single fault flag not cleared");
  a_load_value: assert property (prot_load.valid && !st_q.loaded && !prot_load.double_fault
      |=> st_q.prot == $past(prot_load.value))
    else $error("protection byte not loaded");
  a_load_fault: assert property (prot_load.valid && !st_q.loaded && prot_load.double_fault
      |=> st_q.prot == PROT_FULL)
    else $error("faulted load not fully protected");
  a_cmd_refuse: assert property (cmd.valid && !cmd.block_erase
      && addr_protected(st_q.prot, cmd.addr) |=> cmd_refused && st_q.protection_violation_flag)
    else $error("protected program not refused");
  a_blk_erase: assert property (cmd.valid && cmd.block_erase
      && scen_of(st_q.prot) != SCEN_OPEN |=> cmd_refused && !cmd_granted)
    else $error("block erase not refused");
  a_size_lock: assert property (!st_q.prot.high_window_disable && !prot_load.valid
      |=> st_q.prot.high_window_size == $past(st_q.prot.high_window_size))
    else $error("high size changed while window on");
  a_scen_reject: assert property (wr_take && hit_prot && !wr_allowed && !prot_load.valid
      |=> $stable(st_q.prot))
    else $error("disallowed scenario accepted");
  a_irq_follow: assert property (st_q.double_fault_flag && st_q.double_fault_irq_enable
      |-> ##[0:1] double_fault_irq)
    else $error("double fault interrupt missing");
  a_viol_clear: assert property (wr_take && hit_cmd && pwdata[4] && !cmd.valid
      |=> !st_q.protection_violation_flag)
    else $error("violation flag not cleared");
  a_lo_lock: assert property (!st_q.prot.low_window_disable && !prot_load.valid
      |=> st_q.prot.low_window_size == $past(st_q.prot.low_window_size))
    else $error("low size changed while window on");
  a_viol_keep: assert property (wr_take && hit_cmd && !pwdata[4]
      && st_q.protection_violation_flag |=> st_q.protection_violation_flag)
    else $error("violation flag lost on zero write");

  c_refused: cover property (cmd.valid ##1 cmd_refused);
  c_scen_change: cover property (wr_take && hit_prot && wr_allowed
      ##1 !$stable(st_q.prot));
  c_dbl_irq: cover property ((fault_evt.double_fault || fault_evt.busy_block_read)
      ##1 double_fault_irq);
  c_load_fault: cover property (prot_load.valid && prot_load.double_fault);

endmodule

`default_nettype wire

/* File: include/fesp_pkg.sv */
// Constants, register layouts and carrier types for the flash fault status and
// program-flash protection block.
// Assumes an APB master with 32-bit data and byte addresses of one word per register.
package fesp_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0]  IDX_CONFIG   = 8'h03;
  localparam logic [7:0]  IDX_ERR_CFG  = 8'h05;
  localparam logic [7:0]  IDX_CMD_STAT = 8'h06;
  localparam logic [7:0]  IDX_FAULT    = 8'h07;
  localparam logic [7:0]  IDX_PROT     = 8'h08;

  // Field positions.
  localparam int unsigned BIT_DOUBLE_FAULT = 1;
  localparam int unsigned BIT_SINGLE_FAULT = 0;
  localparam int unsigned BIT_IGNORE_SF    = 4;
  localparam int unsigned BIT_VIOLATION    = 4;

  // Reset and fallback values of the protection register.
  localparam logic [7:0]  PROT_FULL = 8'h7F;

  // Location of the stored protection byte fetched by the reset sequence.
  localparam logic [23:0] PROT_BYTE_ADDR = 24'h7F_FF0C;

  // Window geometry.
  localparam logic [23:0] PF_TOP_EXCL = 24'h80_0000;
  localparam logic [23:0] HI_MIN_SIZE = 24'h00_0800;
  localparam logic [23:0] LO_BASE     = 24'h7F_8000;
  localparam logic [23:0] LO_MIN_SIZE = 24'h00_0400;

  // Allowed scenario transitions: row is the present scenario, bit is the target.
  localparam logic [7:0][7:0] PROT_TRANS = {
    8'hFF, 8'h5A, 8'h3C, 8'h18, 8'h08, 8'h0C, 8'h0A, 8'h0F
  };
  localparam logic [2:0] SCEN_OPEN = 3'h7;

  typedef struct packed {
    logic       protection_open;
    logic       reserved_nonvolatile_bit;
    logic       high_window_disable;
    logic [1:0] high_window_size;
    logic       low_window_disable;
    logic [1:0] low_window_size;
  } fesp_prot_type;

  typedef struct packed {
    logic double_fault;
    logic single_fault;
    logic busy_block_read;
  } fesp_fault_evt_type;

  typedef struct packed {
    logic        valid;
    logic        block_erase;
    logic [22:0] addr;
  } fesp_cmd_type;

  typedef struct packed {
    logic       valid;
    logic       double_fault;
    logic [7:0] value;
  } fesp_load_type;

endpackage

/* File: test/fesp_top_tb.sv */
// Self-checking bench for the flash fault status and program-flash protection block.
// Assumes the design package and the top module are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module fesp_top_tb;
  import fesp_pkg::*;
  logic               clock;
  logic               rst;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [11:0]        paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  fesp_fault_evt_type fault_evt;
  fesp_load_type      prot_load;
  fesp_cmd_type       cmd;
  logic               cmd_refused;
  logic               cmd_granted;
  logic               prot_loaded;
  logic               double_fault_irq;
  logic               single_fault_irq;
  int                 fails;
  int                 n_compared;
  int                 cycles;

  fesp_top DUT (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_evt(fault_evt), .prot_load(prot_load), .cmd(cmd), .cmd_refused(cmd_refused),
    .cmd_granted(cmd_granted), .prot_loaded(prot_loaded),
    .double_fault_irq(double_fault_irq), .single_fault_irq(single_fault_irq)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // The ceiling is about a hundred times the length of the whole sequence.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  // One APB transfer; the request is held until pready is sampled high.
  // Only the bench timeout ends a wait that never gets an answer.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] r;
    logic        e;
    apb(1'b1, {2'b00, idx, 2'b00}, {24'h000000, v}, r, e);
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] ex);
    logic [31:0] r;
    logic        e;
    apb(1'b0, {2'b00, idx, 2'b00}, 32'h00000000, r, e);
    `CHK({e, r}, {1'b0, 24'h000000, ex})
  endtask

  task automatic pulse(input fesp_fault_evt_type f);
    @(posedge clock) fault_evt <= f;
    @(posedge clock) fault_evt <= '0;
  endtask

  task automatic chk_cmd(input logic be, input logic [22:0] a, input logic refused);
    @(posedge clock) cmd <= '{valid: 1'b1, block_erase: be, addr: a};
    @(posedge clock) cmd <= '0;
    #1;
    `CHK({cmd_refused, cmd_granted}, {refused, ~refused})
  endtask

  task automatic load(input logic df, input logic [7:0] v);
    @(posedge clock) prot_load <= '{valid: 1'b1, double_fault: df, value: v};
    @(posedge clock) prot_load <= '0;
    #1;
    `CHK(prot_loaded, 1'b1)
  endtask

  task automatic do_reset();
    @(posedge clock) rst <= 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
  endtask

  task automatic t_load();
    rchk(IDX_PROT, 8'h7F);
    wr(IDX_PROT, 8'hBF);
    rchk(IDX_PROT, 8'h7F);
    load(1'b1, 8'h55);
    rchk(IDX_PROT, 8'h7F);
    do_reset();
    load(1'b0, 8'hFF);
    rchk(IDX_PROT, 8'hFF);
    $display("test load done");
  endtask

  task automatic t_faults();
    logic [31:0] r;
    logic        e;
    rchk(IDX_FAULT, 8'h00);
    pulse(3'b100);
    rchk(IDX_FAULT, 8'h02);
    wr(IDX_FAULT, 8'h00);
    rchk(IDX_FAULT, 8'h02);
    wr(IDX_FAULT, 8'h02);
    rchk(IDX_FAULT, 8'h00);
    wr(IDX_CONFIG, 8'h10);
    pulse(3'b010);
    rchk(IDX_FAULT, 8'h00);
    wr(IDX_CONFIG, 8'h00);
    pulse(3'b010);
    rchk(IDX_FAULT, 8'h01);
    wr(IDX_FAULT, 8'h00);
    rchk(IDX_FAULT, 8'h01);
    wr(IDX_FAULT, 8'h01);
    rchk(IDX_FAULT, 8'h00);
    wr(IDX_ERR_CFG, 8'h02);
    pulse(3'b001);
    rchk(IDX_FAULT, 8'h03);
    `CHK({double_fault_irq, single_fault_irq}, 2'b10)
    wr(IDX_ERR_CFG, 8'h01);
    @(posedge clock);
    #1;
    `CHK({double_fault_irq, single_fault_irq}, 2'b01)
    wr(IDX_FAULT, 8'h03);
    repeat (2) @(posedge clock);
    #1;
    `CHK({double_fault_irq, single_fault_irq}, 2'b00)
    // An unmapped word must answer with an error and read zero.
    apb(1'b0, 12'h3FC, 32'h00000000, r, e);
    `CHK({e, r}, 33'h100000000)
    $display("test faults done");
  endtask

  task automatic t_prot();
    chk_cmd(1'b1, 23'h7F_0000, 1'b0);
    chk_cmd(1'b0, PROT_BYTE_ADDR[22:0], 1'b0);
    wr(IDX_PROT, 8'hDC);
    rchk(IDX_PROT, 8'hDC);
    chk_cmd(1'b0, PROT_BYTE_ADDR[22:0], 1'b1);
    wr(IDX_PROT, 8'hFC);
    rchk(IDX_PROT, 8'hDC);
    chk_cmd(1'b0, 23'h7F_C000, 1'b1);
    chk_cmd(1'b0, 23'h7F_BFFF, 1'b0);
    chk_cmd(1'b1, 23'h7F_0000, 1'b1);
    rchk(IDX_CMD_STAT, 8'h10);
    wr(IDX_CMD_STAT, 8'h00);
    rchk(IDX_CMD_STAT, 8'h10);
    wr(IDX_CMD_STAT, 8'h10);
    rchk(IDX_CMD_STAT, 8'h00);
    wr(IDX_PROT, 8'hD8);
    rchk(IDX_PROT, 8'hD8);
    chk_cmd(1'b0, 23'h7F_83FF, 1'b1);
    chk_cmd(1'b0, 23'h7F_8400, 1'b0);
    wr(IDX_PROT, 8'hDB);
    rchk(IDX_PROT, 8'hD8);
    wr(IDX_PROT, 8'hC8);
    rchk(IDX_PROT, 8'hD8);
    wr(IDX_PROT, 8'h7C);
    rchk(IDX_PROT, 8'h7C);
    chk_cmd(1'b0, 23'h7F_4000, 1'b1);
    wr(IDX_PROT, 8'h40);
    rchk(IDX_PROT, 8'h7C);
    $display("test protection done");
  endtask

  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; fault_evt = '0; prot_load = '0; cmd = '0;
    fails = 0; n_compared = 0; cycles = 0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_load();
    t_faults();
    t_prot();
    report_and_stop();
  end
endmodule
`default_nettype wire
